// File: fct_monitor.sv
// checker of divider set-once and command timing at the block ports
`timescale 1ns/1ps
module fct_monitor #(
   parameter int DIV_W = 7,
   parameter int PULSE_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic div_wr,
   input wire logic [DIV_W-1:0] div_wdata,
   input wire logic access_error_flag,
   input wire logic cmd_valid,
   input wire logic [DIV_W-1:0] flash_clock_divider,
   input wire logic div_loaded,
   input wire logic cmd_accept,
   input wire logic cmd_reject,
   input wire logic busy,
   input wire logic hv_enable,
   input wire logic pulse_active,
   input wire logic cmd_done,
   input wire logic flash_timing_clock
);
   logic [7:0] gap_q;
   logic seen_q;
   logic ftc_q;
   wire toggle = flash_timing_clock != ftc_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // bus cycles since the last edge of the timing clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= 8'h00;
         seen_q <= 1'h0;
         ftc_q <= 1'h0;
      end else begin
         ftc_q <= flash_timing_clock;
         seen_q <= seen_q | toggle;
         gap_q <= toggle ? 8'h00 : gap_q + 8'h01;
      end
   end
   // a command that the idle, loaded block must take
   sequence s_take;
      cmd_valid && div_loaded && !busy;
   endsequence
   a_reject_unloaded: assert property (cmd_valid && !div_loaded |=> cmd_reject && !cmd_accept)
      else $error("command taken before divider written");
   a_busy_refuse: assert property (cmd_valid && busy |=> cmd_reject && !cmd_accept)
      else $error("command taken while busy");
   a_div_take: assert property (div_wr && !access_error_flag && !div_loaded
      |=> div_loaded && flash_clock_divider == $past(div_wdata))
      else $error("divider write not stored");
   a_div_hold: assert property (div_loaded |=> div_loaded && $stable(flash_clock_divider))
      else $error("stored divider changed");
   a_err_block: assert property (div_wr && access_error_flag && !div_loaded |=> !div_loaded)
      else $error("divider written while error set");
   a_tick_period: assert property (toggle && seen_q |-> gap_q == 8'(flash_clock_divider))
      else $error("timing clock period wrong");
   a_take_cmd: assert property (s_take |=> cmd_accept && busy && hv_enable)
      else $error("command not started");
   a_hv_cover: assert property (pulse_active |-> hv_enable && busy)
      else $error("pulse without voltages on");
   a_done_end: assert property ($fell(busy) |-> cmd_done)
      else $error("busy fell without done");
   a_pulse_align: assert property ($rose(pulse_active) || $fell(pulse_active)
      |-> $fell(flash_timing_clock))
      else $error("pulse edge off a timing clock period end");
endmodule
bind fct_top fct_monitor #(.DIV_W(DIV_W), .PULSE_W(PULSE_W)) i_fct_monitor (.clk(clk),
   .rst_n(rst_n), .div_wr(div_wr), .div_wdata(div_wdata), .cmd_valid(cmd_valid),
   .access_error_flag(access_error_flag), .flash_clock_divider(flash_clock_divider),
   .div_loaded(div_loaded), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .busy(busy),
   .hv_enable(hv_enable), .pulse_active(pulse_active), .cmd_done(cmd_done),
   .flash_timing_clock(flash_timing_clock));

// File: fct_pkg.sv
// package for the flash clock and command timing block
package fct_pkg;
   // ---------------------------------------------------------------
   // sizes and timing
   // ---------------------------------------------------------------
   localparam int PAGE_COUNT = 32;
   localparam int PAGE_BYTES = 512;
   localparam int PAGE_W = 5;
   localparam int DIV_W = 7;
   localparam int PULSE_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
   localparam int REF_PERIOD_NS = 5000; // reference timing clock period, 5 us
   localparam int CLK_PERIOD_NS = 20;
   localparam int REF_DIV_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [PULSE_W-1:0] SETUP_TICKS = 16'h0002; // voltage enable
   localparam logic [PULSE_W-1:0] HOLD_TICKS = 16'h0002; // voltage disable

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FCT_CMD_PROG = 2'h0,
      FCT_CMD_PAGE_ERASE = 2'h1,
      FCT_CMD_MASS_ERASE = 2'h2
   } fct_cmd_e;

   typedef struct packed {
      fct_cmd_e cmd;
      logic [PAGE_W-1:0] page;
      logic [PULSE_W-1:0] pulse_ticks;
   } fct_req_s;

   typedef enum logic [1:0] {
      FCT_IDLE = 2'b00,
      FCT_SETUP = 2'b01,
      FCT_PULSE = 2'b11,
      FCT_HOLD = 2'b10
   } fct_state_e;
endpackage

// File: fct_tick_div.sv
// divider that makes the flash timing clock tick from the bus clock
`timescale 1ns/1ps
module fct_tick_div #(
   parameter int DIV_W = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [DIV_W-1:0] div_val,
   output logic tick
);
   logic [DIV_W:0] cnt_q;
   logic [DIV_W:0] limit;
   wire at_end;

   // period is (div_val + 1) bus clocks
   assign limit = {1'b0, div_val};
   assign at_end = (cnt_q >= limit);

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         cnt_q <= at_end ? '0 : cnt_q + 1'b1;
         tick <= at_end;
      end
   end
endmodule

// File: fct_top.sv
// flash clock divider set-once logic and command pulse timing
// Operation
// RULE1: refuse every program or erase command until divider written
// RULE2: software picks divider giving 150 to 200 kHz timing clock
// RULE3: divider accepts one write after reset; later writes ignored
// RULE4: divider write ignored while access error flag is set
// RULE5: software checks access error clear before writing divider
// RULE6: timing clock derived by dividing bus clock by divider value; the code divides it by twice (divider + 1)
// RULE7: pulses timed as whole timing clock periods, one count each
// RULE8: command time includes overhead and voltage enable, disable
// RULE9: array is 32 pages of 512 bytes; erase addressed by page
`timescale 1ns/1ps
module fct_top #(
   parameter int DIV_W = fct_pkg::DIV_W,
   parameter int PULSE_W = fct_pkg::PULSE_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic div_wr,
   input wire logic [DIV_W-1:0] div_wdata,
   input wire logic access_error_flag,
   input wire logic cmd_valid,
   input wire fct_pkg::fct_req_s cmd_req,
   output logic [DIV_W-1:0] flash_clock_divider,
   output logic div_loaded,
   output logic cmd_accept,
   output logic cmd_reject,
   output logic busy,
   output logic hv_enable,
   output logic pulse_active,
   output logic [fct_pkg::PAGE_W-1:0] erase_page,
   output logic mass_erase,
   output logic cmd_done,
   output logic flash_timing_clock
);
   fct_pkg::fct_state_e state_q;
   fct_pkg::fct_state_e state_d;
   logic [PULSE_W-1:0] ticks_q;
   logic [PULSE_W-1:0] pulse_len_q;
   wire tick;
   wire div_take;
   wire cmd_take;
   wire cmd_refuse;
   wire last_tick;
   wire period_end;
   wire setup_end;
   wire pulse_end;
   wire hold_end;
   wire busy_d;
   wire pulse_d;
   wire [PULSE_W-1:0] pulse_len_d;

   // ---------------------------------------------------------------
   // divider register
   // ---------------------------------------------------------------
   // RULE3 RULE4 single write gate
   // a write refused for the error flag leaves the register open, so
   // software can clear the flag and try again
   assign div_take = div_wr && !div_loaded && !access_error_flag;

   // stored once, then held until the next reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_clock_divider <= fct_pkg::DIV_RESET;
         div_loaded <= 1'b0;
      end else if (div_take) begin
         flash_clock_divider <= div_wdata;
         div_loaded <= 1'b1;
      end
   end

   // RULE6 bus clock divide
   fct_tick_div #(
      .DIV_W(DIV_W)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .run(div_loaded),
      .div_val(flash_clock_divider),
      .tick(tick)
   );

   // timing clock toggles on each tick, so one period is two ticks
   // and a period spans twice (div + 1) bus clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_timing_clock <= 1'b0;
      end else if (tick) begin
         flash_timing_clock <= ~flash_timing_clock;
      end
   end

   // ---------------------------------------------------------------
   // timing clock period
   // ---------------------------------------------------------------
   // RULE7 one count per period
   // a period ends on the tick that takes the clock low again; counting
   // bare ticks would run every phase at twice the intended rate
   assign period_end = tick && flash_timing_clock;

   // ---------------------------------------------------------------
   // command acceptance
   // ---------------------------------------------------------------
   // RULE1 refuse before divider
   // until the divider is stored no period is known, so nothing may start
   assign cmd_take = cmd_valid && div_loaded && (state_q == fct_pkg::FCT_IDLE);
   assign cmd_refuse = cmd_valid && !cmd_take;
   assign last_tick = period_end && (ticks_q == '0);

   // phase ends of the running command
   assign setup_end = last_tick && (state_q == fct_pkg::FCT_SETUP);
   assign pulse_end = last_tick && (state_q == fct_pkg::FCT_PULSE);
   assign hold_end = last_tick && (state_q == fct_pkg::FCT_HOLD);

   // a zero length request runs as one period so the pulse never stalls
   assign pulse_len_d = (cmd_req.pulse_ticks == '0) ? 16'h0001 : cmd_req.pulse_ticks;

   // one answer per cycle of cmd_valid, accept or refuse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
      end else begin
         cmd_accept <= cmd_take;
         cmd_reject <= cmd_refuse;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // RULE8 setup pulse hold phases
   // program, page erase and mass erase share the same phases
   always_comb begin
      state_d = state_q;
      case (state_q)
         fct_pkg::FCT_IDLE: begin
            if (cmd_take) begin
               state_d = fct_pkg::FCT_SETUP;
            end
         end
         fct_pkg::FCT_SETUP: begin
            if (last_tick) begin
               state_d = fct_pkg::FCT_PULSE;
            end
         end
         fct_pkg::FCT_PULSE: begin
            if (last_tick) begin
               state_d = fct_pkg::FCT_HOLD;
            end
         end
         fct_pkg::FCT_HOLD: begin
            if (last_tick) begin
               state_d = fct_pkg::FCT_IDLE;
            end
         end
         default: begin
            state_d = fct_pkg::FCT_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= fct_pkg::FCT_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // RULE7 whole period count
   // ticks_q holds the periods left in the phase, minus one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks_q <= '0;
         pulse_len_q <= '0;
      end else if (cmd_take) begin
         ticks_q <= fct_pkg::SETUP_TICKS - 1'b1;
         pulse_len_q <= pulse_len_d;
      end else if (setup_end) begin
         ticks_q <= pulse_len_q - 1'b1;
      end else if (pulse_end) begin
         ticks_q <= fct_pkg::HOLD_TICKS - 1'b1;
      end else if (period_end && ticks_q != '0) begin
         ticks_q <= ticks_q - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // RULE9 page addressed erase
   // page and mass flag captured with the command, kept for its run
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         erase_page <= '0;
         mass_erase <= 1'b0;
      end else if (cmd_take) begin
         erase_page <= cmd_req.page;
         mass_erase <= (cmd_req.cmd == fct_pkg::FCT_CMD_MASS_ERASE);
      end
   end

   // next levels come from state_d so the outputs line up with state_q;
   // voltages stay on from setup through hold, the pulse only between
   assign busy_d = (state_d != fct_pkg::FCT_IDLE);
   assign pulse_d = (state_d == fct_pkg::FCT_PULSE);

   // status outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         hv_enable <= 1'b0;
         pulse_active <= 1'b0;
         cmd_done <= 1'b0;
      end else begin
         busy <= busy_d;
         hv_enable <= busy_d;
         pulse_active <= pulse_d;
         cmd_done <= hold_end;
      end
   end
endmodule

// File: fct_top_bench.sv
// self-checking bench for the flash clock and command timing block
`timescale 1ns/1ps
module fct_top_bench;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic div_wr = 1'h0;
   logic [6:0] div_wdata = 7'h00;
   logic access_error_flag = 1'h0;
   logic cmd_valid = 1'h0;
   fct_pkg::fct_req_s cmd_req = '0;
   logic [6:0] flash_clock_divider;
   logic div_loaded, cmd_accept, cmd_reject, busy, hv_enable, pulse_active;
   logic mass_erase, cmd_done, flash_timing_clock;
   logic [fct_pkg::PAGE_W-1:0] erase_page;
   int fail_count = 0;
   int check_count = 0;
   fct_top i_fct_top (.clk, .rst_n, .div_wr, .div_wdata, .access_error_flag, .cmd_valid,
      .cmd_req, .flash_clock_divider, .div_loaded, .cmd_accept, .cmd_reject, .busy,
      .hv_enable, .pulse_active, .erase_page, .mass_erase, .cmd_done, .flash_timing_clock);
   initial forever #10 clk = ~clk;
   task automatic finish_test();
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask
   // command before any divider write
   task automatic t_unloaded();
      cmd_valid = 1'h1;
      cyc();
      cmd_valid = 1'h0;
      chk("cmd_reject", cmd_reject, 32'h1);
   endtask
   // divider write while the access error is set
   task automatic t_error();
      access_error_flag = 1'h1;
      div_wr = 1'h1;
      div_wdata = 7'h05;
      cyc();
      div_wr = 1'h0;
      access_error_flag = 1'h0;
      chk("div_loaded", div_loaded, 32'h0);
   endtask
   // first write kept, back-to-back second write ignored
   task automatic t_load();
      // an edge passes so div_wr is not lowered and raised at once
      cyc();
      // error flag already clear before the write
      div_wr = 1'h1;
      // two halves of 125 bus clocks: 5 us period, 200 kHz at 50 MHz
      div_wdata = 7'h7c;
      cyc();
      div_wdata = 7'h7f;
      cyc();
      div_wr = 1'h0;
      chk("div_loaded", div_loaded, 32'h1);
      chk("divider", flash_clock_divider, 32'h7c);
   endtask
   // one command, a refused repeat while busy, pulse length in bus cycles
   task automatic t_cmd(int c);
      int n;
      n = 0;
      cmd_req.cmd = fct_pkg::fct_cmd_e'(c);
      cmd_req.page = 5'h1f;
      cmd_req.pulse_ticks = 16'(c);
      cmd_valid = 1'h1;
      cyc();
      chk("cmd_accept", cmd_accept, 32'h1);
      chk("erase_page", erase_page, 32'h1f);
      chk("mass_erase", mass_erase, 32'(c == 2));
      cyc();
      cmd_valid = 1'h0;
      chk("cmd_reject", cmd_reject, 32'h1);
      for (int i = 0; i < 2000 && cmd_done !== 1'h1; i++) begin
         n += pulse_active;
         cyc();
      end
      chk("pulse_len", n, (c == 0 ? 1 : c) * fct_pkg::REF_DIV_CYCLES);
      chk("cmd_done", cmd_done, 32'h1);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'h1;
      t_unloaded();
      t_error();
      t_load();
      for (int c = 0; c < 3; c++) t_cmd(c);
      finish_test();
   end
   initial begin
      repeat (12000) @(posedge clk);
      fail_count++;
      finish_test();
   end
endmodule
